// [pkg/pscp_defs.svh]
// Purpose: Constants of the passive serial configuration port.
// Assumes: Core clock of 25 MHz; times are kept in their own unit.
// Notes:   Cycle counts are derived from the times by the users.
`ifndef PSCP_DEFS_SVH
`define PSCP_DEFS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define PSCP_CLK_MHZ        25
`define PSCP_USERCLK_MAX_MHZ 125
`define PSCP_INIT_CYCLES    8532
`define PSCP_RESTART_US     500
`define PSCP_POR_SLOW_MS    100
`define PSCP_POR_FAST_MS    4
`define PSCP_INIT_DELAY_US  2
`define PSCP_KICK_EDGES     2

// ****************************************************************
// Image layout
// ****************************************************************
`define PSCP_SYNC_NIBBLE    4'ha
`define PSCP_OPT_STARTUP    0
`define PSCP_OPT_USERCLK    1
`define PSCP_IMAGE_BITS     4096

`endif

// [pkg/pscp_pkg.sv]
// Purpose: Types of the passive serial configuration port.
// Assumes: Constants come from pscp_defs.svh.
// Notes:   Only the state type is shared between files.
package pscp_pkg;

    // ************************************************************
    // Stages of the configuration cycle
    // ************************************************************
    typedef enum logic [2:0]
    {
        PSCP_POR,
        PSCP_RESET,
        PSCP_LOAD,
        PSCP_WAIT,
        PSCP_INIT,
        PSCP_USER,
        PSCP_ERROR
    } pscp_state_e;

endpackage

// [verilog/pscp_tick_count.sv]
// Purpose: Counts a fixed number of cycles of its own clock.
// Assumes: The go level comes from another clock domain.
// Notes:   Used to count initialization cycles on the user clock.
`timescale 1ns/10ps

module pscp_tick_count
#(
    parameter int COUNT = 8532
)
(
    input  wire logic clk,   // Counting clock.
    input  wire logic nrst,  // Asynchronous reset, active low.
    input  wire logic go,    // Start level, foreign domain.
    output logic      done   // High once COUNT cycles have passed.
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed
    {
        logic        s1;    // First synchroniser stage.
        logic        s2;    // Second synchroniser stage.
        logic [15:0] cnt;   // Cycles counted so far.
        logic        done;  // Count reached.
    } pscp_tick_s;

    pscp_tick_s q_ff;   // Registered state.
    pscp_tick_s nxt_q;  // Next state.

    // Counting stops while go is low, so a new start counts afresh.
    always_comb
    begin
        nxt_q    = q_ff;
        nxt_q.s1 = go;
        nxt_q.s2 = q_ff.s1;
        if (!q_ff.s2)
        begin
            nxt_q.cnt  = 16'h0000;
            nxt_q.done = 1'b0;
        end
        else if (q_ff.cnt == 16'(COUNT - 1))
        begin
            nxt_q.done = 1'b1;
        end
        else
        begin
            nxt_q.cnt = q_ff.cnt + 16'h0001;
        end
    end

    // Register the state.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            q_ff <= '0;
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    assign done = q_ff.done;

endmodule

// [verilog/pscp_top.sv]
// Purpose: Passive serial configuration port of a programmable device.
// Assumes: nrst is power-on reset; the host clocks serial_clock_in.
// Notes:   Open-drain pins are split into pin, drive and enable; start-up-complete has no pin.
// What this block does
// - Capture one data bit per serial rising edge.
// - Stay in reset while request or status low.
// - Request rising releases status, then accept data.
// - Release load-complete after full error-free image.
// - Internal oscillator clocks init; later serial clocks ignored.
// - User clock init needs 8532 cycles, 125 MHz max.
// - Start-up-complete low after option bit, high at end.
// - User mode removes weak pull-ups from user pins.
// - Serial clock may pause for any time.
// - Error pulls status low and resets internally.
// - Auto restart releases status within 500 us.
// - Request low in user mode resets, tri-states I/O.
// - Power-on holds status low; delay chosen by select.
// - Pull select low enables weak pull-ups before user.
`timescale 1ns/10ps
`include "pscp_defs.svh"

module pscp_top
#(
    parameter int IMAGE_BITS  = `PSCP_IMAGE_BITS,
    parameter int POR_SLOW    = `PSCP_POR_SLOW_MS * 1000 * `PSCP_CLK_MHZ,
    parameter int POR_FAST    = `PSCP_POR_FAST_MS * 1000 * `PSCP_CLK_MHZ,
    parameter int RESTART_CYC = `PSCP_RESTART_US * `PSCP_CLK_MHZ
)
(
    input  wire logic clk,                     // Internal oscillator, 25 MHz.
    input  wire logic nrst,                    // Power-on reset, active low.
    input  wire logic serial_clock_in,         // Host serial clock.
    input  wire logic serial_data_in,          // Host serial data.
    input  wire logic user_startup_clock,      // Optional user start-up clock.
    input  wire logic config_req_n,            // Configuration request, active low.
    input  wire logic status_n_pin,            // Level seen on the status line.
    output logic      status_n_drv,            // Status drive value, always low.
    output logic      status_n_oe,             // Status pulled low when high.
    input  wire logic load_complete_pin,       // Level seen on load-complete line.
    output logic      load_complete_drv,       // Load-complete drive value, low.
    output logic      load_complete_oe,        // Load-complete pulled low when high.
    output logic      startup_complete_drv,    // Start-up-complete drive value, low.
    output logic      startup_complete_oe,     // Start-up-complete pulled low.
    input  wire logic power_on_delay_select,   // High picks the fast power-on delay.
    input  wire logic weak_pull_select_n,      // Low enables weak pull-ups.
    input  wire logic auto_restart_enable,     // High restarts itself after error.
    output logic      weak_pull_enable,        // Weak pull-ups on user pins.
    output logic      user_io_enable,          // User I/O may drive; else tri-stated.
    output logic      user_mode                // Device is in user mode.
);
    import pscp_pkg::*;

    localparam int DELAY_CYC = `PSCP_INIT_DELAY_US * `PSCP_CLK_MHZ;
    localparam int IW        = $clog2(IMAGE_BITS + 1);

    // ************************************************************
    // Link domain: serial shift-in on the host clock
    // ************************************************************
    typedef struct packed
    {
        logic [7:0]    sh;    // Byte being assembled, LSB arrives first.
        logic [2:0]    bits;  // Bit position inside the byte.
        logic [IW-1:0] cnt;   // Bits taken so far.
        logic [7:0]    opt;   // Option byte of the first frame.
        logic          ov;    // Option byte has arrived.
        logic          done;  // Whole image taken.
        logic          err;   // Image header was wrong.
        logic [1:0]    kick;  // Host clock edges seen after done.
    } pscp_link_s;

    pscp_link_s lq_ff;     // Link state.
    pscp_link_s nxt_lq;    // Next link state.
    logic       link_rst_n; // Link reset, held while the core is not armed.
    logic [7:0] byte_w;    // Byte completed by this edge.

    // Capture stops after done or error, so extra clocks do no harm.
    always_comb
    begin
        nxt_lq = lq_ff;
        byte_w = {serial_data_in, lq_ff.sh[7:1]};
        if (!lq_ff.done && !lq_ff.err)
        begin
            nxt_lq.sh   = byte_w;
            nxt_lq.bits = lq_ff.bits + 3'h1;
            nxt_lq.cnt  = lq_ff.cnt + IW'(1);
            if (lq_ff.bits == 3'h7 && !lq_ff.ov)
            begin
                nxt_lq.opt = byte_w;
                nxt_lq.ov  = 1'b1;
                nxt_lq.err = (byte_w[7:4] != `PSCP_SYNC_NIBBLE);
            end
            if (lq_ff.cnt == IW'(IMAGE_BITS - 1))
            begin
                nxt_lq.done = 1'b1;
            end
        end
        else if (lq_ff.done && lq_ff.kick != 2'(`PSCP_KICK_EDGES))
        begin
            // A second rising edge proves the second falling edge passed.
            nxt_lq.kick = lq_ff.kick + 2'h1;
        end
    end

    // The reset leaves before the host's first edge, which comes later.
    always_ff @(posedge serial_clock_in or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            lq_ff <= '0;
        end
        else
        begin
            lq_ff <= nxt_lq;
        end
    end

    // ************************************************************
    // Core domain: stages of the configuration cycle
    // ************************************************************
    typedef struct packed
    {
        pscp_state_e st;       // Current stage.
        logic [23:0] cnt;      // Shared delay counter.
        logic [1:0]  req;      // Request synchroniser.
        logic [1:0]  sts;      // Status pin synchroniser.
        logic [1:0]  ldc;      // Load-complete pin synchroniser.
        logic [1:0]  pul;      // Pull select synchroniser.
        logic [1:0]  sel;      // Delay select synchroniser.
        logic [1:0]  aut;      // Auto restart synchroniser.
        logic [1:0]  dn;       // Link done synchroniser.
        logic [1:0]  er;       // Link error synchroniser.
        logic [1:0]  ov;       // Option valid synchroniser.
        logic [1:0]  kk;       // Kick synchroniser.
        logic [1:0]  uc;       // User clock count synchroniser.
        logic        fast;     // Fast power-on delay caught.
        logic        arm;      // Link may run.
        logic        st_low;   // Pull status low.
        logic        cd_low;   // Pull load-complete low.
        logic        su_low;   // Pull start-up-complete low.
        logic        ugo;      // Count on the user clock.
        logic        user;     // User mode.
    } pscp_core_s;

    pscp_core_s q_ff;      // Core state.
    pscp_core_s nxt_q;     // Next core state.
    logic       uc_done;   // User clock count finished.
    logic       kicked;    // Both falling edges and pull-up seen.
    logic [23:0] por_lim;  // Power-on delay in cycles.

    assign link_rst_n = nrst & q_ff.arm;
    assign kicked     = q_ff.kk[1] && q_ff.ldc[1];
    assign por_lim    = q_ff.fast ? 24'(POR_FAST - 1) : 24'(POR_SLOW - 1);

    // Option bits are read only once their valid flag has crossed,
    // after which the link never changes them.
    always_comb
    begin
        nxt_q     = q_ff;
        nxt_q.req = {q_ff.req[0], config_req_n};
        nxt_q.sts = {q_ff.sts[0], status_n_pin};
        nxt_q.ldc = {q_ff.ldc[0], load_complete_pin};
        nxt_q.pul = {q_ff.pul[0], weak_pull_select_n};
        nxt_q.sel = {q_ff.sel[0], power_on_delay_select};
        nxt_q.aut = {q_ff.aut[0], auto_restart_enable};
        nxt_q.dn  = {q_ff.dn[0], lq_ff.done};
        nxt_q.er  = {q_ff.er[0], lq_ff.err};
        nxt_q.ov  = {q_ff.ov[0], lq_ff.ov};
        nxt_q.kk  = {q_ff.kk[0], lq_ff.kick == 2'(`PSCP_KICK_EDGES)};
        nxt_q.uc  = {q_ff.uc[0], uc_done};
        unique case (q_ff.st)
            PSCP_POR:
            begin
                // The select strap is caught once it has settled.
                if (q_ff.cnt < 24'h000004)
                begin
                    nxt_q.fast = q_ff.sel[1];
                end
                nxt_q.cnt = q_ff.cnt + 24'h000001;
                if (q_ff.cnt >= por_lim)
                begin
                    nxt_q.st  = PSCP_RESET;
                    nxt_q.cnt = 24'h000000;
                end
            end
            PSCP_RESET:
            begin
                // Release status when the request is high; stay while low.
                nxt_q.st_low = !q_ff.req[1];
                if (q_ff.req[1] && q_ff.sts[1])
                begin
                    nxt_q.st  = PSCP_LOAD;
                    nxt_q.arm = 1'b1;
                end
            end
            PSCP_LOAD:
            begin
                nxt_q.su_low = q_ff.ov[1] && lq_ff.opt[`PSCP_OPT_STARTUP];
                if (q_ff.er[1])
                begin
                    nxt_q.st     = PSCP_ERROR;
                    nxt_q.st_low = 1'b1;
                    nxt_q.arm    = 1'b0;
                    nxt_q.su_low = 1'b0;
                    nxt_q.cnt    = 24'h000000;
                end
                else if (q_ff.dn[1])
                begin
                    nxt_q.st     = PSCP_WAIT;
                    nxt_q.cd_low = 1'b0;
                    nxt_q.cnt    = 24'h000000;
                end
            end
            PSCP_WAIT:
            begin
                if (kicked)
                begin
                    nxt_q.cnt = q_ff.cnt + 24'h000001;
                    if (q_ff.cnt == 24'(DELAY_CYC - 1))
                    begin
                        nxt_q.st  = PSCP_INIT;
                        nxt_q.cnt = 24'h000000;
                        nxt_q.ugo = lq_ff.opt[`PSCP_OPT_USERCLK];
                    end
                end
            end
            PSCP_INIT:
            begin
                // Internal oscillator by default; no serial clock needed.
                nxt_q.cnt = q_ff.cnt + 24'h000001;
                if (q_ff.ugo ? q_ff.uc[1] : q_ff.cnt == 24'(`PSCP_INIT_CYCLES - 1))
                begin
                    nxt_q.st     = PSCP_USER;
                    nxt_q.su_low = 1'b0;
                    nxt_q.user   = 1'b1;
                    nxt_q.ugo    = 1'b0;
                end
            end
            PSCP_USER:
            begin
                nxt_q.user = 1'b1;
            end
            PSCP_ERROR:
            begin
                // Without auto restart only a request pulse leaves here.
                if (q_ff.aut[1])
                begin
                    nxt_q.cnt = q_ff.cnt + 24'h000001;
                    if (q_ff.cnt == 24'(RESTART_CYC - 1))
                    begin
                        nxt_q.st     = PSCP_RESET;
                        nxt_q.st_low = 1'b0;
                        nxt_q.cnt    = 24'h000000;
                    end
                end
            end
            default:
            begin
                nxt_q.st = PSCP_RESET;
            end
        endcase
        // A low request outside power-on reset restarts everything.
        if (!q_ff.req[1] && q_ff.st != PSCP_POR)
        begin
            nxt_q.st     = PSCP_RESET;
            nxt_q.st_low = 1'b1;
            nxt_q.cd_low = 1'b1;
            nxt_q.su_low = 1'b0;
            nxt_q.ugo    = 1'b0;
            nxt_q.user   = 1'b0;
            nxt_q.arm    = 1'b0;
            nxt_q.cnt    = 24'h000000;
        end
    end

    // Register the core state; status and load-complete start low.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            q_ff        <= '0;
            q_ff.st     <= PSCP_POR;
            q_ff.st_low <= 1'b1;
            q_ff.cd_low <= 1'b1;
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    // ************************************************************
    // Initialization count on the user start-up clock
    // ************************************************************
    pscp_tick_count
    #(
        .COUNT (`PSCP_INIT_CYCLES)
    )
    u_user_count
    (
        .clk  (user_startup_clock),
        .nrst (nrst),
        .go   (q_ff.ugo),
        .done (uc_done)
    );

    // ************************************************************
    // Pins
    // ************************************************************
    assign status_n_drv         = 1'b0;
    assign status_n_oe          = q_ff.st_low;
    assign load_complete_drv    = 1'b0;
    assign load_complete_oe     = q_ff.cd_low;
    assign startup_complete_drv = 1'b0;
    assign startup_complete_oe  = q_ff.su_low;
    assign weak_pull_enable     = !q_ff.pul[1] && !q_ff.user;
    assign user_io_enable       = q_ff.user;
    assign user_mode            = q_ff.user;

    // ************************************************************
    // Checks
    // ************************************************************
    chk_por_status: assert property (@(posedge clk) disable iff (!nrst)
        q_ff.st == PSCP_POR |-> status_n_oe && !user_io_enable)
        else $error("status not held low in power-on reset");
    chk_reset_hold: assert property (@(posedge clk) disable iff (!nrst)
        q_ff.st == PSCP_RESET && !(q_ff.req[1] && q_ff.sts[1])
        |=> q_ff.st != PSCP_LOAD)
        else $error("left reset while request or status low");
    chk_load_done: assert property (@(posedge clk) disable iff (!nrst)
        q_ff.st == PSCP_LOAD && q_ff.dn[1] && !q_ff.er[1] && q_ff.req[1]
        |=> !load_complete_oe)
        else $error("load-complete not released after image");
    chk_err_status: assert property (@(posedge clk) disable iff (!nrst)
        q_ff.st == PSCP_LOAD && q_ff.er[1] |=> status_n_oe && !q_ff.arm)
        else $error("error did not pull status low");
    chk_restart_bound: assert property (@(posedge clk) disable iff (!nrst)
        q_ff.st == PSCP_ERROR |-> q_ff.cnt < 24'(RESTART_CYC))
        else $error("restart time-out exceeded");
    chk_user_req: assert property (@(posedge clk) disable iff (!nrst)
        q_ff.st == PSCP_USER && !q_ff.req[1]
        |=> status_n_oe && load_complete_oe && !user_io_enable)
        else $error("request low in user mode not honoured");
    chk_init_count: assert property (@(posedge clk) disable iff (!nrst)
        $rose(q_ff.st == PSCP_USER) && !$past(q_ff.ugo)
        |-> $past(q_ff.cnt) == 24'(`PSCP_INIT_CYCLES - 1))
        else $error("internal initialization count wrong");
    chk_user_pulls: assert property (@(posedge clk) disable iff (!nrst)
        user_mode |-> !weak_pull_enable && !startup_complete_oe)
        else $error("pull-ups or start-up line wrong in user mode");
    chk_link_capture: assert property (@(posedge serial_clock_in)
        disable iff (!link_rst_n)
        !lq_ff.done && !lq_ff.err |=> lq_ff.sh[7] == $past(serial_data_in))
        else $error("serial bit not captured");

endmodule

// [testbench/pscp_host.sv]
// Purpose: Host model that loads an image over the serial link.
// Assumes: Status and load-complete wires are pulled up by the bench.
// Notes:   The serial clock only runs while bits are being sent.
`timescale 1ns/10ps

module pscp_host
#(
    parameter int GAP_NS = 2000     // Start wait; long request wait is shortened.
)
(
    output logic      sclk,         // Serial clock, 48 ns period in frames.
    output logic      sdata,        // Serial data line.
    output logic      req_n,        // Configuration request, active low.
    input  wire logic status_n,     // Status wire level.
    input  wire logic done          // Load-complete wire level.
);
    // ************************************************************
    // Link driving
    // ************************************************************
    // Lines are always driven, so the device never sees a float.
    initial
    begin
        sclk  = 1'b0;
        sdata = 1'b0;
        req_n = 1'b1;
    end

    // Data is set with the clock low, so setup is half a period.
    task automatic bit_out(input logic b);
    begin
        sdata = b;
        #24 sclk = 1'b1;
        #24 sclk = 1'b0;
    end
    endtask

    // A request pulse of 2 us restarts a device without auto restart.
    task automatic restart();
    begin
        req_n = 1'b0;
        #2000 req_n = 1'b1;
    end
    endtask

    // Sends a 32 bit image, byte 0 first and LSB first, with one pause when pause_at is below 32.
    task automatic send(input logic [31:0] img, input int pause_at);
        int i;
    begin
        wait (status_n === 1'b1);
        #(GAP_NS);
        for (i = 0; i < 32; i++)
        begin
            if (i == pause_at)
                #5000;
            bit_out(img[i]);
        end
        // A refused image never raises load-complete, so no kick follows.
        for (i = 0; i < 10 && done !== 1'b1; i++)
            #40;
        if (done === 1'b1)
        begin
            bit_out(1'b0);
            bit_out(1'b0);
        end
        sdata = 1'b0;
    end
    endtask
endmodule

// [testbench/tb_pscp_top.sv]
// Purpose: Self-checking bench of the serial configuration port.
// Assumes: Counts other than the init count and the 2 us init delay are shortened through the top parameters.
// Notes:   Random image bits come from a fixed-seed xorshift.
`timescale 1ns/10ps

module tb_pscp_top;
    logic        clk, nrst, uclk, dsel, psel_n, auto_rst;  // Bench driven inputs.
    logic        st_drv, st_oe, ld_drv, ld_oe, su_drv, su_oe;  // Open-drain sides.
    logic        wpull, io_en, umode;                 // Mode outputs.
    logic        sclk, sdata, req_n;                  // Host driven link.
    logic        st_pin, ld_pin;                      // Wire levels with pull-ups.
    logic [31:0] seed = 32'h7a503d2a;                 // Xorshift state.
    logic [31:0] img, r;                              // Image and scratch.
    int          err_total, n_tests, n, k;            // Counters.

    // Pull-ups win unless the device enables its low drive.
    assign st_pin = st_oe ? st_drv : 1'b1;
    assign ld_pin = ld_oe ? ld_drv : 1'b1;

    pscp_top #(.IMAGE_BITS(32), .POR_SLOW(40), .POR_FAST(20), .RESTART_CYC(50)) dut
    (
        .clk(clk), .nrst(nrst), .serial_clock_in(sclk), .serial_data_in(sdata),
        .user_startup_clock(uclk), .config_req_n(req_n), .status_n_pin(st_pin),
        .status_n_drv(st_drv), .status_n_oe(st_oe), .load_complete_pin(ld_pin),
        .load_complete_drv(ld_drv), .load_complete_oe(ld_oe),
        .startup_complete_drv(su_drv), .startup_complete_oe(su_oe),
        .power_on_delay_select(dsel), .weak_pull_select_n(psel_n),
        .auto_restart_enable(auto_rst), .weak_pull_enable(wpull),
        .user_io_enable(io_en), .user_mode(umode)
    );

    pscp_host host
    (
        .sclk(sclk), .sdata(sdata), .req_n(req_n), .status_n(st_pin), .done(ld_pin)
    );

    // Core clock of 25 MHz and a user start-up clock at its 125 MHz limit.
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        uclk = 1'b0;
        forever #4 uclk = ~uclk;
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] rnd();
    begin
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    end
    endfunction

    // Image with a header byte: sync nibble (or a bad one) and two options.
    function automatic logic [31:0] image(input logic su, input logic uc, input logic ok);
        logic [31:0] x;
    begin
        x = rnd();
        return {x[31:8], (ok ? 4'ha : 4'h5), 2'b00, uc, su};
    end
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    begin
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    end
    endtask

    // Inputs move 1 ns after the edge, never on it.
    task automatic tick(input int c);
    begin
        repeat (c) @(posedge clk);
        #1;
    end
    endtask

    // Bounded wait for the status drive to reach a level; n counts cycles.
    task automatic wait_st(input logic v, input int lim, output int c);
    begin
        c = 0;
        while (st_oe !== v && c < lim)
        begin
            tick(1);
            c++;
        end
        check("status wait", c < lim, 1'b1);
    end
    endtask

    // Power-on reset held 3 cycles, then the delay is measured.
    task automatic por(input logic fast, input int dly);
    begin
        nrst = 1'b0;
        dsel = fast;
        tick(3);
        check("por status", st_oe, 1'b1);
        check("por io", io_en, 1'b0);
        check("por done", ld_oe, 1'b1);
        check("drive lows", {st_drv, ld_drv, su_drv}, 3'h0);
        nrst = 1'b1;
        wait_st(1'b0, 200, n);
        check("por delay", n >= dly && n <= dly + 12, 1'b1);
    end
    endtask

    // Init must take its cycles, then user mode ends every hold.
    task automatic run_init(input int lo, input int hi);
    begin
        for (n = 0; umode !== 1'b1 && n < hi + 10; n++)
            tick(1);
        check("init cycles", n >= lo && n <= hi, 1'b1);
        check("user io", io_en, 1'b1);
        check("startup end", su_oe, 1'b0);
        check("pullups off", wpull, 1'b0);
    end
    endtask

    task automatic stop_test();
    begin
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask

    // Cuts a hang short; the tests need well under a millisecond.
    initial
    begin
        #3000000;
        err_total++;
        stop_test();
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial
    begin
        nrst = 1'b0;
        dsel = 1'b0;
        psel_n = 1'b0;
        auto_rst = 1'b0;
        err_total = 0;
        n_tests = 0;
        por(1'b0, 40);
        check("pullups on", wpull, 1'b1);
        // Good image, start-up output, internal oscillator, pause mid-byte.
        img = image(1'b1, 1'b0, 1'b1);
        r = rnd();
        host.send(img, int'(r[4:0]));
        tick(4);
        check("load done", ld_oe, 1'b0);
        check("startup low", su_oe, 1'b1);
        for (k = 0; k < 3; k++)
        begin
            r = rnd();
            host.bit_out(r[0]);
        end
        run_init(8532, 8620);
        // Request low in user mode resets and tri-states.
        fork
            host.restart();
            begin
                tick(10);
                check("req status", st_oe, 1'b1);
                check("req done", ld_oe, 1'b1);
                check("req io", io_en, 1'b0);
                check("req mode", umode, 1'b0);
            end
        join
        wait_st(1'b0, 20, n);
        // Bad header with auto restart: flagged, then released in time.
        auto_rst = 1'b1;
        fork
            host.send(image(1'b0, 1'b0, 1'b0), 40);
            begin
                wait_st(1'b1, 2000, n);
                wait_st(1'b0, 100, n);
                check("restart time", n >= 40 && n <= 62, 1'b1);
            end
        join
        // Bad header without auto restart: status stays low.
        auto_rst = 1'b0;
        tick(2);
        fork
            host.send(image(1'b1, 1'b1, 1'b0), 40);
            begin
                wait_st(1'b1, 2000, n);
                tick(150);
                check("error hold", st_oe, 1'b1);
            end
        join
        // Load-complete never rose, so the host restarts the device.
        host.restart();
        // Good image timed by the user clock, start-up output off.
        host.send(image(1'b0, 1'b1, 1'b1), 3);
        tick(4);
        check("load done 2", ld_oe, 1'b0);
        check("no startup", su_oe, 1'b0);
        psel_n = 1'b1;
        tick(4);
        check("pullups off", wpull, 1'b0);
        run_init(1706, 1800);
        por(1'b1, 20);
        stop_test();
    end
endmodule
